/* pkg/prr_pkg.sv */
// Constants, field layouts and carrier types for the ring-resiliency register bank
// Notes on behaviour
// - Bit 10 flags memory integrity event, clears on read
// - Bits 9..5 flag security engine events, clear on read
// - Bit 4 flags switchover complete, clears on read
// - Bits 3..0 flag energy-efficient Ethernet events, clear on read
// - Mask bit at same position enables interrupt source
// - Control bits 15,14,12 sticky read/write; 13 partner copy
// - Status field 5:4: 00 slave,10,11 master,01
// - Stable role follows autonegotiation at first link-up
// - Page register value 3 opens extended page 3
// - Page 3 redirects addresses 16..30 to page 3
// - Addresses 0..15 never depend on page
// - Page register value 0 restores main space
package prr_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [4:0] IDX_MASK = 5'h1C;
    localparam logic [4:0] IDX_PEND = 5'h1D;
    localparam logic [4:0] IDX_RING = 5'h1E;
    localparam logic [4:0] IDX_PAGE = 5'h1F;
    localparam logic [4:0] IDX_PAGED_LO = 5'h10;
    // Page select values
    localparam logic [15:0] PAGE_MAIN = 16'h0000;
    localparam logic [15:0] PAGE_EXT2 = 16'h0002;
    localparam logic [15:0] PAGE_EXT3 = 16'h0003;
    // Event vector width and layout
    localparam int EVT_W = 11;
    localparam int EVT_SWITCH = 4;
    localparam logic [EVT_W-1:0] EVT_RESET = 11'h000;
    // Ring-resiliency register fields
    localparam int RB_START_EN = 15;
    localparam int RB_ADV = 14;
    localparam int RB_LP_ADV = 13;
    localparam int RB_FORCE = 12;
    localparam int RB_ST_HI = 5;
    localparam int RB_ST_LO = 4;
    localparam int RB_GO = 0;
    // Ring-resiliency role codes
    localparam logic [1:0] RR_SLAVE = 2'h0;
    localparam logic [1:0] RR_S2M = 2'h2;
    localparam logic [1:0] RR_MASTER = 2'h3;
    localparam logic [1:0] RR_M2S = 2'h1;
    // One-hot switchover states
    typedef enum logic [3:0] {
        ST_SLAVE = 4'h1,
        ST_S2M = 4'h2,
        ST_MASTER = 4'h4,
        ST_M2S = 4'h8
    } prr_rr_state_t;
    // Switchover engine state
    typedef struct packed {
        prr_rr_state_t st;
        logic link_seen;
        logic complete;
    } prr_rr_t;
    // Request forwarded to registers outside this bank
    typedef struct packed {
        logic stb;
        logic we;
        logic [4:0] adr;
        logic [15:0] page;
        logic [15:0] dat;
    } prr_fwd_t;
    // Control bits of the ring-resiliency register
    typedef struct packed {
        logic start_en;
        logic adv;
        logic force_en;
    } prr_ctl_t;
    // State of the bank, apart from the switchover sequencer state
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic busy;
        prr_fwd_t fwd;
        logic [15:0] page;
        logic [EVT_W-1:0] mask;
        logic [EVT_W-1:0] pend;
        prr_ctl_t ctl;
        logic go;
        logic irq;
    } prr_regs_t;
endpackage

/* verilog/prr_switch_fsm.sv */
// Ring-resiliency timing role tracker and switchover sequencer
module prr_switch_fsm
    import prr_pkg::*;
(
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic ce_i, // Clock enable
    input wire logic link_up_i, // Link up level
    input wire logic an_master_i, // Autoneg chose master
    input wire logic start_i, // Start request pulse
    input wire logic done_i, // Timing recovery handover done
    output logic [1:0] role_o, // Encoded role field
    output logic busy_o, // Switchover in flight
    output logic complete_o // One-cycle completion pulse
);
    prr_rr_t s_q; // Registered state
    prr_rr_t s_d; // Next state

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.complete = 1'b0;
        // First link-up fixes the stable role
        if (link_up_i && !s_q.link_seen) begin
            s_d.link_seen = 1'b1;
            s_d.st = an_master_i ? ST_MASTER : ST_SLAVE;
        end else begin
            unique case (s_q.st)
                ST_SLAVE: begin
                    if (start_i) begin
                        s_d.st = ST_S2M;
                    end
                end
                ST_MASTER: begin
                    if (start_i) begin
                        s_d.st = ST_M2S;
                    end
                end
                ST_S2M: begin
                    // A second start here is ignored
                    if (done_i) begin
                        s_d.st = ST_MASTER;
                        s_d.complete = 1'b1;
                    end
                end
                ST_M2S: begin
                    if (done_i) begin
                        s_d.st = ST_SLAVE;
                        s_d.complete = 1'b1;
                    end
                end
                default: begin
                    // Illegal code recovers to slave
                    s_d.st = ST_SLAVE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{st: ST_SLAVE, link_seen: 1'b0, complete: 1'b0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // Role encoding
    always_comb begin
        unique case (s_q.st)
            ST_S2M: role_o = RR_S2M;
            ST_MASTER: role_o = RR_MASTER;
            ST_M2S: role_o = RR_M2S;
            default: role_o = RR_SLAVE;
        endcase
    end

    assign busy_o = s_q.st[1] | s_q.st[3];
    assign complete_o = s_q.complete;
endmodule

/* verilog/prr_regs.sv */
// Extended interrupt, ring-resiliency and page-select register bank on Wishbone
module prr_regs
    import prr_pkg::*;
(
    input wire logic clk_i, // Core clock, 25 MHz
    input wire logic rst_i, // Synchronous reset, high
    input wire logic ce_i, // Clock enable, freezes all
    // Wishbone classic slave
    input wire logic cyc_i, // Bus cycle
    input wire logic stb_i, // Strobe
    input wire logic we_i, // Write enable
    input wire logic [6:0] adr_i, // Byte address
    input wire logic [3:0] sel_i, // Byte selects
    input wire logic [31:0] dat_i, // Write data
    output logic [31:0] dat_o, // Read data
    output logic ack_o, // Acknowledge
    // Event sources, same clock, one-cycle pulses
    input wire logic [EVT_W-1:0] evt_i, // Interrupt events
    output logic irq_o, // Level interrupt
    // PHY core status, same clock
    input wire logic link_up_i, // Link up
    input wire logic an_master_i, // Autoneg master result
    input wire logic lp_adv_i, // Partner advertises ring mode
    input wire logic sw_done_i, // Switchover handover done
    output logic [1:0] rr_role_o, // Current role field
    output logic rr_start_en_o, // Startup enable
    output logic rr_adv_o, // Advertise ring mode
    output logic rr_force_o, // Force ring mode
    // Forwarded accesses to other register blocks
    output logic ext_stb_o, // Forwarded request
    output logic ext_we_o, // Forwarded write
    output logic [4:0] ext_adr_o, // Register number
    output logic [15:0] ext_page_o, // Page, zero below 16
    output logic [15:0] ext_dat_o, // Forwarded write data
    input wire logic ext_ack_i, // Forwarded answer
    input wire logic [15:0] ext_dat_i // Forwarded read data
);
    prr_regs_t r_q; // Registered state
    prr_regs_t r_d; // Next state
    logic [1:0] role; // Role from sequencer flops
    logic sw_busy; // Switchover in flight
    logic sw_complete; // Completion pulse
    logic [4:0] idx; // Register number
    logic req; // New bus request
    logic own; // Access hits this bank
    logic paged; // Address in paged window
    logic [15:0] wmask; // Byte-lane write mask
    logic [15:0] wdat; // Masked write data
    logic [15:0] rdat; // Own read value
    logic [EVT_W-1:0] clr; // Pending bits cleared now

    // Switchover sequencer
    prr_switch_fsm u_fsm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .link_up_i(link_up_i),
        .an_master_i(an_master_i),
        .start_i(r_q.go),
        .done_i(sw_done_i),
        .role_o(role),
        .busy_o(sw_busy),
        .complete_o(sw_complete)
    );

    // Address decode
    always_comb begin
        idx = adr_i[6:2];
        req = cyc_i && stb_i && !r_q.ack && !r_q.busy;
        paged = (idx >= IDX_PAGED_LO) && (idx != IDX_PAGE);
        // Low registers never follow the page
        own = (idx == IDX_PAGE);
        // Mask, pending and ring registers live on extended page 2 only
        if (r_q.page == PAGE_EXT2) begin
            own = own || (idx == IDX_MASK) || (idx == IDX_PEND) || (idx == IDX_RING);
        end
        wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
        wdat = dat_i[15:0] & wmask;
    end

    // Read multiplexer for own registers
    always_comb begin
        rdat = 16'h0000;
        unique case (idx)
            IDX_MASK: rdat[EVT_W-1:0] = r_q.mask;
            IDX_PEND: rdat[EVT_W-1:0] = r_q.pend;
            IDX_RING: begin
                rdat[RB_START_EN] = r_q.ctl.start_en;
                rdat[RB_ADV] = r_q.ctl.adv;
                rdat[RB_LP_ADV] = lp_adv_i;
                rdat[RB_FORCE] = r_q.ctl.force_en;
                rdat[RB_ST_HI:RB_ST_LO] = role;
            end
            IDX_PAGE: rdat = r_q.page;
            default: rdat = 16'h0000;
        endcase
    end

    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.ack = 1'b0;
        r_d.go = 1'b0;
        clr = EVT_RESET;
        if (req && own) begin
            // Own registers answer one cycle after the request
            r_d.ack = 1'b1;
            r_d.dat = {16'h0000, rdat};
            if (!we_i && idx == IDX_PEND) begin
                // Reading the pending register clears what it showed
                clr = r_q.pend;
            end
            if (we_i) begin
                unique case (idx)
                    IDX_MASK: begin
                        r_d.mask = (r_q.mask & ~wmask[EVT_W-1:0])
                            | wdat[EVT_W-1:0];
                    end
                    IDX_PEND: begin
                        // Writing ones also clears pending bits
                        clr = wdat[EVT_W-1:0];
                    end
                    IDX_RING: begin
                        if (sel_i[1]) begin
                            r_d.ctl.start_en = dat_i[RB_START_EN];
                            r_d.ctl.adv = dat_i[RB_ADV];
                            r_d.ctl.force_en = dat_i[RB_FORCE];
                        end
                        // Start only from a stable role; reads back zero
                        if (sel_i[0] && dat_i[RB_GO] && !sw_busy) begin
                            r_d.go = 1'b1;
                        end
                    end
                    IDX_PAGE: begin
                        // Value 3 opens page 3, value 0 the main space
                        r_d.page = (r_q.page & ~wmask) | wdat;
                    end
                    default: begin
                        r_d.page = r_q.page;
                    end
                endcase
            end
        end else if (req) begin
            // Foreign address: hand to the owning block
            r_d.busy = 1'b1;
            r_d.fwd.stb = 1'b1;
            r_d.fwd.we = we_i;
            r_d.fwd.adr = idx;
            // Paged window carries the page, 0..15 carry main
            r_d.fwd.page = paged ? r_q.page : PAGE_MAIN;
            r_d.fwd.dat = dat_i[15:0];
        end
        if (r_q.busy && ext_ack_i) begin
            // Forwarded answer closes the bus cycle
            r_d.busy = 1'b0;
            r_d.fwd.stb = 1'b0;
            r_d.ack = 1'b1;
            r_d.dat = {16'h0000, ext_dat_i};
        end
        // New events win over a clear in the same cycle
        r_d.pend = (r_q.pend & ~clr) | evt_i;
        r_d.pend[EVT_SWITCH] = r_d.pend[EVT_SWITCH] | sw_complete;
        r_d.irq = |(r_d.pend & r_d.mask);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else if (ce_i) begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flops, except rr_role_o decoded from sequencer flops
    assign dat_o = r_q.dat;
    assign ack_o = r_q.ack;
    assign irq_o = r_q.irq;
    assign rr_role_o = role;
    assign rr_start_en_o = r_q.ctl.start_en;
    assign rr_adv_o = r_q.ctl.adv;
    assign rr_force_o = r_q.ctl.force_en;
    assign ext_stb_o = r_q.fwd.stb;
    assign ext_we_o = r_q.fwd.we;
    assign ext_adr_o = r_q.fwd.adr;
    assign ext_page_o = r_q.fwd.page;
    assign ext_dat_o = r_q.fwd.dat;
endmodule

/* test/prr_regs_props.sv */
// Bound assertions watching the register bank ports
module prr_regs_props
    import prr_pkg::*;
(
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Synchronous reset
    input wire logic cyc_i, // Bus cycle
    input wire logic stb_i, // Strobe
    input wire logic we_i, // Write enable
    input wire logic [6:0] adr_i, // Byte address
    input wire logic [31:0] dat_o, // Read data
    input wire logic ack_o, // Acknowledge
    input wire logic sw_done_i, // Handover done
    input wire logic [1:0] rr_role_o, // Role field
    input wire logic rr_start_en_o, // Startup enable
    input wire logic rr_adv_o, // Advertise
    input wire logic rr_force_o, // Force
    input wire logic ext_stb_o, // Forwarded request
    input wire logic [4:0] ext_adr_o, // Forwarded register
    input wire logic [15:0] ext_page_o, // Forwarded page
    input wire logic ext_ack_i, // Forwarded answer
    input wire logic [15:0] ext_dat_i // Forwarded data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers are single pulses
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    // The page register is always local and answers next cycle
    chk_page_local: assert property (cyc_i && stb_i && !ack_o && !ext_stb_o
        && adr_i[6:2] == IDX_PAGE |=> ack_o) else $error("page access not answered");
    // Low addresses never carry a page
    chk_low_unpaged: assert property (ext_stb_o && ext_adr_o < 5'h10
        |-> ext_page_o == 16'h0000) else $error("low register paged");
    // Forwarded request held until answered
    chk_fwd_held: assert property (ext_stb_o && !ext_ack_i
        |=> ext_stb_o && $stable(ext_adr_o) && $stable(ext_page_o)) else $error("fwd dropped");
    // Forwarded answer passed straight back
    chk_fwd_answer: assert property (ext_stb_o && ext_ack_i
        |=> ack_o && !ext_stb_o && dat_o[15:0] == $past(ext_dat_i)) else $error("fwd data lost");
    // Control bits move only with a write
    chk_ctl_by_write: assert property ($changed({rr_start_en_o, rr_adv_o, rr_force_o})
        |-> ack_o && we_i) else $error("control changed without write");
    chk_switch_master: assert property (rr_role_o == RR_S2M && sw_done_i
        |=> rr_role_o == RR_MASTER) else $error("no master after handover");
    chk_switch_slave: assert property (rr_role_o == RR_M2S && sw_done_i
        |=> rr_role_o == RR_SLAVE) else $error("no slave after handover");
    // A slave-to-master switchover in flight is not disturbed
    chk_busy_hold: assert property (rr_role_o == RR_S2M && !sw_done_i
        |=> rr_role_o == RR_S2M) else $error("switchover disturbed");
    cover property (ext_stb_o && ext_ack_i);
    cover property (rr_role_o == RR_S2M && sw_done_i);
    cover property (rr_role_o == RR_M2S && sw_done_i);
endmodule
bind prr_regs prr_regs_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .sw_done_i, .rr_role_o, .rr_start_en_o, .rr_adv_o, .rr_force_o, .ext_stb_o,
    .ext_adr_o, .ext_page_o, .ext_ack_i, .ext_dat_i);

/* test/prr_ext_model.sv */
// Behavioural answerer for accesses forwarded to other register pages
module prr_ext_model (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Synchronous reset
    input wire logic slow_i, // Stretch the answer
    input wire logic stb_i, // Forwarded request
    input wire logic [4:0] adr_i, // Register number
    input wire logic [15:0] page_i, // Page of the access
    output logic ack_o, // One-cycle answer
    output logic [15:0] dat_o // Read data, junk when idle
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt;
    // Idle data toggles so a stale read never matches by luck
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 16'hC3C3;
        end else if (!stb_i || ack_o) begin
            ack_o <= 1'b0;
            wait_cnt <= 0;
            dat_o <= ~dat_o;
        end else if (wait_cnt >= (slow_i ? 6 : 0)) begin
            ack_o <= 1'b1;
            dat_o <= {page_i[3:0], 7'h00, adr_i} ^ 16'h5A00;
        end else begin
            wait_cnt <= wait_cnt + 1;
            dat_o <= ~dat_o;
        end
    end
endmodule

/* test/testbench.sv */
// Self-checking bench for the ring-resiliency register bank
module testbench
    import prr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, slow = 1'b0;
    logic link_up_i = 1'b0, an_master_i = 1'b0, lp_adv_i = 1'b1, sw_done_i = 1'b0;
    logic [6:0] adr_i = 7'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [EVT_W-1:0] evt_i = 11'h000;
    logic ack_o, irq_o, rr_start_en_o, rr_adv_o, rr_force_o, ext_stb_o, ext_we_o, ext_ack_i;
    logic [1:0] rr_role_o;
    logic [4:0] ext_adr_o;
    logic [15:0] ext_page_o, ext_dat_o, ext_dat_i, m, v;
    logic [15:0] exp_q[$]; // Expected read data in order
    logic ce_i = 1'b1; // Clock enable, dropped once to prove the freeze
    logic fwd_we = 1'b0; // Forwarded access expected to be a write
    logic [15:0] fwd_dat = 16'h0000; // Expected forwarded write data
    int error_cnt = 0, compares = 0, cycles = 0, seed = 20318;
    always #20 clk_i = ~clk_i;
    prr_regs DUT (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .evt_i, .irq_o, .link_up_i, .an_master_i, .lp_adv_i, .sw_done_i,
        .rr_role_o, .rr_start_en_o, .rr_adv_o, .rr_force_o, .ext_stb_o, .ext_we_o, .ext_adr_o,
        .ext_page_o, .ext_dat_o, .ext_ack_i, .ext_dat_i);
    prr_ext_model u_ext (.clk_i, .rst_i, .slow_i(slow), .stb_i(ext_stb_o), .adr_i(ext_adr_o),
        .page_i(ext_page_o), .ack_o(ext_ack_i), .dat_o(ext_dat_i));
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Classic single cycle; waits for ack under a bound
    task automatic wb(input logic w, input logic [4:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'hF;
        dat_i <= {16'h0000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 300) error_cnt++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] idx, input logic [15:0] e);
        exp_q.push_back(e);
        wb(1'b0, idx, 16'h0000);
    endtask
    // Event pulse, then time for pending and interrupt to settle
    task automatic pulse(input logic [10:0] e);
        evt_i <= e;
        @(posedge clk_i);
        evt_i <= 11'h000;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wait_role(input logic [1:0] r);
        int n;
        n = 0;
        while (rr_role_o !== r && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check({14'h0000, rr_role_o}, {14'h0000, r});
    endtask
    task automatic handover();
        sw_done_i <= 1'b1;
        @(posedge clk_i);
        sw_done_i <= 1'b0;
    endtask
    function automatic logic [15:0] ext_val(input logic [4:0] a, input logic [15:0] p);
        return {p[3:0], 7'h00, a} ^ 16'h5A00;
    endfunction
    // Read data monitor takes the oldest note per read answer
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) check(dat_o[15:0], exp_q.pop_front());
    end
    // Forwarded direction and write data, looked at on the answering edge
    always @(posedge clk_i) begin
        if (ext_stb_o === 1'b1 && ext_ack_i === 1'b1) begin
            check({15'h0000, ext_we_o}, {15'h0000, fwd_we});
            if (fwd_we) check(ext_dat_o, fwd_dat);
        end
    end
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IDX_PAGE, PAGE_MAIN);
        wb(1'b1, IDX_PAGE, PAGE_EXT2);
        rd(IDX_MASK, 16'h0000);
        rd(IDX_PEND, 16'h0000);
        rd(IDX_RING, 16'h2000);
        $display("test reset values done");
        for (int i = 0; i < EVT_W; i++) begin
            wb(1'b1, IDX_MASK, 16'h0001 << i);
            pulse(11'h001 << i);
            check({15'h0000, irq_o}, 16'h0001);
            rd(IDX_PEND, 16'h0001 << i);
            rd(IDX_PEND, 16'h0000);
            check({15'h0000, irq_o}, 16'h0000);
        end
        repeat (4) begin
            m = 16'($random(seed));
            v = 16'($random(seed));
            wb(1'b1, IDX_MASK, m);
            rd(IDX_MASK, m & 16'h07FF);
            pulse(v[10:0]);
            check({15'h0000, irq_o}, {15'h0000, |(m[10:0] & v[10:0])});
            rd(IDX_PEND, v & 16'h07FF);
        end
        // Events while the clock enable is low must leave no trace
        ce_i <= 1'b0;
        pulse(11'h7FF);
        check({15'h0000, irq_o}, 16'h0000);
        ce_i <= 1'b1;
        rd(IDX_PEND, 16'h0000);
        $display("test events done");
        wb(1'b1, IDX_RING, 16'hD000);
        check({13'h0000, rr_start_en_o, rr_adv_o, rr_force_o}, 16'h0007);
        rd(IDX_RING, 16'hF000);
        wb(1'b1, IDX_RING, 16'h0000);
        wb(1'b1, IDX_MASK, 16'h0010);
        an_master_i <= 1'b1;
        link_up_i <= 1'b1;
        wait_role(RR_MASTER);
        an_master_i <= 1'b0;
        wb(1'b1, IDX_RING, 16'h0001);
        wait_role(RR_M2S);
        wb(1'b1, IDX_RING, 16'h0001);
        handover();
        wait_role(RR_SLAVE);
        repeat (3) @(posedge clk_i);
        check({14'h0000, rr_role_o}, {14'h0000, RR_SLAVE});
        check({15'h0000, irq_o}, 16'h0001);
        rd(IDX_PEND, 16'h0010);
        rd(IDX_RING, 16'h2000);
        wb(1'b1, IDX_RING, 16'h0001);
        wait_role(RR_S2M);
        handover();
        wait_role(RR_MASTER);
        rd(IDX_RING, 16'h2030);
        rd(IDX_PEND, 16'h0010);
        $display("test switchover done");
        wb(1'b1, IDX_PAGE, PAGE_EXT3);
        rd(IDX_PAGE, PAGE_EXT3);
        slow <= 1'b1;
        rd(5'h11, ext_val(5'h11, 16'h0003));
        rd(IDX_PEND, ext_val(IDX_PEND, 16'h0003));
        // A page 3 write to index 30 goes outward and leaves the bank alone
        fwd_we <= 1'b1;
        fwd_dat <= 16'hA5C3;
        wb(1'b1, IDX_RING, 16'hA5C3);
        fwd_we <= 1'b0;
        check({13'h0000, rr_start_en_o, rr_adv_o, rr_force_o}, 16'h0000);
        check({14'h0000, rr_role_o}, {14'h0000, RR_MASTER});
        slow <= 1'b0;
        rd(5'h05, ext_val(5'h05, 16'h0000));
        wb(1'b1, IDX_PAGE, PAGE_MAIN);
        rd(5'h14, ext_val(5'h14, 16'h0000));
        $display("test paging done");
        complete_run();
    end
endmodule
